// ---- core/eodst_decoder.sv ----
// Extended four-byte opcode decoder with execution-state calculator.
// Assumes instruction bytes and cycle counts are presented synchronous to ref_clk.
// Function
// - The top bit of the fourth byte's upper nibble selects between the two groups sharing leading bytes.
// - In register bit encodings one nibble of the second byte is a general register selector.
// - In absolute bit encodings the second byte is an 8-bit short absolute operand address.
// - Six cycle kinds are counted separately: fetch, branch read, stack, byte data, word data, internal.
// - Total states are the sum over the six kinds of count times states per cycle for that kind.
// - States per cycle follow target and width; on-chip memory takes 2 and internal operation 1.
// - On-chip modules take 6 per fetch or word and 3 per byte on 8 bits, and 3 per fetch on 16 bits.
// - External 8-bit three-state takes 6+2m per word and 3+m per byte; two-state takes 4 and 2.
`timescale 1ns/100ps
module eodst_decoder #(
	parameter int TOTAL_W = 16
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic instrValid,
	input wire logic [31:0] instrBytes,
	input eodst_pkg::eodst_counts_t cycleCounts,
	input eodst_pkg::eodst_access_t fetchAccess,
	input eodst_pkg::eodst_access_t branchAccess,
	input eodst_pkg::eodst_access_t stackAccess,
	input eodst_pkg::eodst_access_t dataAccess,
	output eodst_pkg::eodst_decode_t decoded,
	output logic [TOTAL_W-1:0] totalStates,
	output logic resultValid
);
	import eodst_pkg::*;

	eodst_decode_t decoded_reg, decoded_next;
	logic [TOTAL_W-1:0] totalStates_reg, totalStates_next;
	logic resultValid_reg, resultValid_next;

	logic [7:0] byteA, byteB, byteC, byteD;
	logic [3:0] fourth_byte_upper_nibble;
	logic [7:0] rates [NUM_KINDS];
	logic [7:0] counts [NUM_KINDS];
	eodst_access_t accs [NUM_KINDS];

	assign byteA = instrBytes[31:24];
	assign byteB = instrBytes[23:16];
	assign byteC = instrBytes[15:8];
	assign byteD = instrBytes[7:0];
	assign fourth_byte_upper_nibble = byteD[7:4];

	// Count vector unpacked by kind
	assign counts[KIND_FETCH] = cycleCounts.fetch;
	assign counts[KIND_BRANCH] = cycleCounts.branch;
	assign counts[KIND_STACK] = cycleCounts.stack;
	assign counts[KIND_BYTE] = cycleCounts.byteData;
	assign counts[KIND_WORD] = cycleCounts.wordData;
	assign counts[KIND_INTERNAL] = cycleCounts.internal;
	assign accs[KIND_FETCH] = fetchAccess;
	assign accs[KIND_BRANCH] = branchAccess;
	assign accs[KIND_STACK] = stackAccess;
	assign accs[KIND_BYTE] = dataAccess;
	assign accs[KIND_WORD] = dataAccess;
	assign accs[KIND_INTERNAL] = fetchAccess;

	genvar k;
	generate
		for (k = 0; k < NUM_KINDS; k++) begin : gRate
			if (k == KIND_INTERNAL) begin : gInt
				assign rates[k] = ST_INTERNAL;
			end else begin : gAcc
				eodst_state_rate uRate (
					.access(accs[k]),
					.isByte(k == KIND_BYTE),
					.isFetch(k == KIND_FETCH),
					.rate(rates[k])
				);
			end
		end
	endgenerate

	// Maps a bit-operation second nibble to an operation, honouring the upper-nibble group split
	function automatic eodst_op_t bitOp(input logic [3:0] code, input logic inverted, input logic setGroup,
		input logic lowOpcode);
		eodst_op_t r;
		r = INS_NONE;
		if (setGroup) begin
			case (code)
				NIB_0: r = INS_BIT_SET;
				NIB_1: r = INS_BIT_INVERT;
				NIB_2: r = INS_BIT_CLEAR;
				NIB_7: r = (lowOpcode) ? (inverted ? INS_BIT_ISTORE : INS_BIT_STORE) : INS_NONE;
				default: r = INS_NONE;
			endcase
		end else begin
			case (code)
				NIB_3: r = INS_BIT_TEST;
				NIB_4: r = lowOpcode ? INS_NONE : (inverted ? INS_BIT_IOR : INS_BIT_OR);
				NIB_5: r = lowOpcode ? INS_NONE : (inverted ? INS_BIT_IXOR : INS_BIT_XOR);
				NIB_6: r = lowOpcode ? INS_NONE : (inverted ? INS_BIT_IAND : INS_BIT_AND);
				NIB_7: r = lowOpcode ? INS_NONE : (inverted ? INS_BIT_ILOAD : INS_BIT_LOAD);
				default: r = INS_NONE;
			endcase
		end
		return r;
	endfunction

	// True when the leading two bytes and the third byte's upper nibble name one row of the page
	function automatic logic rowIs(input logic [7:0] first, input logic [7:0] second, input logic [3:0] third,
		input logic [7:0] keyFirst, input logic [7:0] keySecond, input logic [3:0] keyThird);
		return (first == keyFirst) && (second == keySecond) && (third == keyThird);
	endfunction

	// The third byte's upper nibble is part of the row key; its lower nibble picks the column
	logic [3:0] rowNibble;
	logic [3:0] column;
	logic rowCtrl;
	logic rowMul;
	logic rowDiv;
	logic rowLogic;
	logic isBitReg;
	logic isBitAbs;
	logic rowBit;
	assign rowNibble = byteC[7:4];
	assign column = byteC[3:0];
	assign rowCtrl = rowIs(byteA, byteB, rowNibble, OP_LDC_AH, OP_LDC_AL, NIB_6);
	assign rowMul = rowIs(byteA, byteB, rowNibble, OP_LDC_AH, OP_MULS_AL, NIB_5);
	assign rowDiv = rowIs(byteA, byteB, rowNibble, OP_LDC_AH, OP_DIVS_AL, NIB_5);
	assign rowLogic = rowIs(byteA, byteB, rowNibble, OP_LDC_AH, OP_LOG_AL, NIB_6);
	assign isBitReg = (byteA == OP_BREG_TST) || (byteA == OP_BREG_SET);
	assign isBitAbs = (byteA == OP_BABS_TST) || (byteA == OP_BABS_SET);
	assign rowBit = (isBitReg || isBitAbs) && (rowNibble == NIB_6 || rowNibble == NIB_7);

	always_comb begin
		logic inv;
		logic lowOp;
		inv = fourth_byte_upper_nibble[UPPER_MSB];
		lowOp = (rowNibble == NIB_6);
		decoded_next = '0;
		decoded_next.op = INS_NONE;
		if (rowCtrl) begin
			decoded_next.op = INS_CTRL_XFER;
		end else if (rowMul && (column == NIB_0 || column == NIB_2)) begin
			decoded_next.op = INS_SIGNED_MULTIPLY;
		end else if (rowDiv && (column == NIB_1 || column == NIB_3)) begin
			decoded_next.op = INS_SIGNED_DIVIDE;
		end else if (rowLogic) begin
			case (column)
				NIB_4: decoded_next.op = INS_LOGIC_OR;
				NIB_5: decoded_next.op = INS_LOGIC_XOR;
				NIB_6: decoded_next.op = INS_LOGIC_AND;
				default: decoded_next.op = INS_NONE;
			endcase
		end else if (rowBit) begin
			decoded_next.op = bitOp(column, inv, byteA[0], lowOp);
			decoded_next.bitNumber = {1'b0, byteD[6:4]};
			if (isBitReg) begin
				decoded_next.regDirect = 1'b1;
				decoded_next.regSel = byteB[7:4];
			end else begin
				decoded_next.absolute = 1'b1;
				decoded_next.shortAbsoluteField = byteB;
			end
		end
		decoded_next.valid = instrValid && (decoded_next.op != INS_NONE);
		// The last decode stands until the next request is taken
		if (!instrValid) begin
			decoded_next = decoded_reg;
		end
	end

	always_comb begin
		logic [TOTAL_W-1:0] acc;
		acc = '0;
		for (int i = 0; i < NUM_KINDS; i++) begin
			acc = acc + (TOTAL_W'(counts[i]) * TOTAL_W'(rates[i]));
		end
		totalStates_next = instrValid ? acc : totalStates_reg;
		resultValid_next = instrValid;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			decoded_reg <= '0;
			totalStates_reg <= '0;
			resultValid_reg <= 1'b0;
		end else begin
			decoded_reg <= decoded_next;
			totalStates_reg <= totalStates_next;
			resultValid_reg <= resultValid_next;
		end
	end

	assign decoded = decoded_reg;
	assign totalStates = totalStates_reg;
	assign resultValid = resultValid_reg;
endmodule

// ---- core/eodst_pkg.sv ----
// Package for the extended opcode decoder and state-count calculator.
// Assumes a single CPU clock domain; shared by the decoder and its timing leaf.
package eodst_pkg;
	// Leading opcode bytes of the extended page
	localparam logic [7:0] OP_LDC_AH = 8'h01;
	localparam logic [7:0] OP_LDC_AL = 8'h40;
	localparam logic [7:0] OP_MULS_AL = 8'hC0;
	localparam logic [7:0] OP_DIVS_AL = 8'hD0;
	localparam logic [7:0] OP_LOG_AL = 8'hF0;
	localparam logic [7:0] OP_BREG_TST = 8'h7C;
	localparam logic [7:0] OP_BREG_SET = 8'h7D;
	localparam logic [7:0] OP_BABS_TST = 8'h7E;
	localparam logic [7:0] OP_BABS_SET = 8'h7F;
	localparam logic [3:0] NIB_6 = 4'h6;
	localparam logic [3:0] NIB_7 = 4'h7;
	localparam logic [3:0] NIB_0 = 4'h0;
	localparam logic [3:0] NIB_5 = 4'h5;
	localparam logic [3:0] NIB_2 = 4'h2;
	localparam logic [3:0] NIB_3 = 4'h3;
	localparam logic [3:0] NIB_4 = 4'h4;
	localparam logic [3:0] NIB_1 = 4'h1;
	localparam int UPPER_MSB = 3;
	// Cycle kinds
	localparam int KIND_FETCH = 0;
	localparam int KIND_BRANCH = 1;
	localparam int KIND_STACK = 2;
	localparam int KIND_BYTE = 3;
	localparam int KIND_WORD = 4;
	localparam int KIND_INTERNAL = 5;
	localparam int NUM_KINDS = 6;
	// States per cycle
	localparam logic [7:0] ST_ONCHIP = 8'h02;
	localparam logic [7:0] ST_INTERNAL = 8'h01;
	localparam logic [7:0] ST_MOD8_WORD = 8'h06;
	localparam logic [7:0] ST_MOD8_BYTE = 8'h03;
	localparam logic [7:0] ST_MOD16 = 8'h03;
	localparam logic [7:0] ST_EXT8_2_WORD = 8'h04;
	localparam logic [7:0] ST_EXT8_2_BYTE = 8'h02;
	localparam logic [7:0] ST_EXT8_3_WORD = 8'h06;
	localparam logic [7:0] ST_EXT8_3_BYTE = 8'h03;
	localparam logic [7:0] ST_EXT16_2 = 8'h02;
	localparam logic [7:0] ST_EXT16_3 = 8'h03;
	localparam logic [7:0] ZERO8 = 8'h00;

	typedef enum logic [1:0] {
		TGT_ONCHIP = 2'b00,
		TGT_MODULE = 2'b01,
		TGT_EXTERNAL = 2'b10
	} eodst_target_t;

	typedef struct packed {
		eodst_target_t target;
		logic bus16;
		logic threeState;
		logic [3:0] waitCount;
	} eodst_access_t;

	typedef enum logic [4:0] {
		INS_NONE = 5'h00,
		INS_CTRL_XFER = 5'h01,
		INS_SIGNED_MULTIPLY = 5'h02,
		INS_SIGNED_DIVIDE = 5'h03,
		INS_LOGIC_OR = 5'h04,
		INS_LOGIC_XOR = 5'h05,
		INS_LOGIC_AND = 5'h06,
		INS_BIT_TEST = 5'h07,
		INS_BIT_OR = 5'h08,
		INS_BIT_XOR = 5'h09,
		INS_BIT_AND = 5'h0A,
		INS_BIT_LOAD = 5'h0B,
		INS_BIT_SET = 5'h0C,
		INS_BIT_INVERT = 5'h0D,
		INS_BIT_CLEAR = 5'h0E,
		INS_BIT_STORE = 5'h0F,
		INS_BIT_IOR = 5'h10,
		INS_BIT_IXOR = 5'h11,
		INS_BIT_IAND = 5'h12,
		INS_BIT_ILOAD = 5'h13,
		INS_BIT_ISTORE = 5'h14
	} eodst_op_t;

	typedef struct packed {
		logic valid;
		eodst_op_t op;
		logic regDirect;
		logic absolute;
		logic [3:0] regSel;
		logic [7:0] shortAbsoluteField;
		logic [3:0] bitNumber;
	} eodst_decode_t;

	typedef struct packed {
		logic [7:0] fetch;
		logic [7:0] branch;
		logic [7:0] stack;
		logic [7:0] byteData;
		logic [7:0] wordData;
		logic [7:0] internal;
	} eodst_counts_t;
endpackage

// ---- core/eodst_state_rate.sv ----
// States-per-cycle lookup for one access condition.
// Assumes the caller picks the condition for each cycle kind.
`timescale 1ns/100ps
module eodst_state_rate (
	input eodst_pkg::eodst_access_t access,
	input wire logic isByte,
	input wire logic isFetch,
	output logic [7:0] rate
);
	import eodst_pkg::*;
	logic [7:0] waitExt;
	assign waitExt = {4'h0, access.waitCount};

	always_comb begin
		rate = ST_ONCHIP;
		case (access.target)
			TGT_ONCHIP: begin
				rate = ST_ONCHIP;
			end
			TGT_MODULE: begin
				if (access.bus16) begin
					rate = ST_MOD16;
				end else if (isByte) begin
					rate = ST_MOD8_BYTE;
				end else begin
					rate = ST_MOD8_WORD;
				end
			end
			TGT_EXTERNAL: begin
				if (access.bus16) begin
					if (access.threeState) begin
						rate = ST_EXT16_3 + waitExt;
					end else begin
						rate = ST_EXT16_2;
					end
				end else if (access.threeState) begin
					if (isByte) begin
						rate = ST_EXT8_3_BYTE + waitExt;
					end else begin
						rate = ST_EXT8_3_WORD + {waitExt[6:0], 1'b0};
					end
				end else if (isByte) begin
					rate = ST_EXT8_2_BYTE;
				end else begin
					rate = ST_EXT8_2_WORD;
				end
			end
			default: begin
				rate = ST_ONCHIP;
			end
		endcase
		if (isFetch && access.target == TGT_ONCHIP) begin
			rate = ST_ONCHIP;
		end
	end
endmodule

// ---- test/eodst_decoder_asserts.sv ----
// Checker for the extended opcode decoder: timing, field extraction and state sums.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/100ps
module eodst_decoder_asserts
	import eodst_pkg::*;
#(
	parameter int TOTAL_W = 16
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic instrValid,
	input wire logic [31:0] instrBytes,
	input eodst_pkg::eodst_counts_t cycleCounts,
	input eodst_pkg::eodst_access_t fetchAccess,
	input eodst_pkg::eodst_access_t dataAccess,
	input eodst_pkg::eodst_decode_t decoded,
	input wire logic [TOTAL_W-1:0] totalStates,
	input wire logic resultValid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Requests that carry only one kind of cycle
	wire logic onlyF = cycleCounts[39:0] == 40'h00_0000_0000;
	wire logic onlyW = {cycleCounts[47:16], cycleCounts[7:0]} == 40'h00_0000_0000;
	wire logic onlyN = cycleCounts[47:8] == 40'h00_0000_0000;

	chk_result_pulse: assert property (instrValid |=> resultValid) else $error("result missing");
	chk_result_drop: assert property (!instrValid |=> !resultValid) else $error("result without request");
	chk_states_hold: assert property (!instrValid |=> $stable(totalStates)) else $error("state total moved");
	chk_group_select: assert property (instrValid && instrBytes[31:24] == 8'h7C && instrBytes[15:8] == 8'h74
		|=> decoded.op == ($past(instrBytes[7]) ? INS_BIT_IOR : INS_BIT_OR)) else $error("group select wrong");
	chk_reg_select: assert property (instrValid && instrBytes[31:25] == 7'h3E && instrBytes[15:13] == 3'h3
		|=> decoded.regSel == $past(instrBytes[23:20])) else $error("register selector wrong");
	chk_abs_field: assert property (instrValid && instrBytes[31:25] == 7'h3F && instrBytes[15:13] == 3'h3
		|=> decoded.shortAbsoluteField == $past(instrBytes[23:16])) else $error("short address wrong");
	chk_internal_one: assert property (instrValid && onlyN
		|=> totalStates == TOTAL_W'($past(cycleCounts.internal))) else $error("internal rate wrong");
	chk_onchip_fetch: assert property (instrValid && onlyF && fetchAccess.target == TGT_ONCHIP
		|=> totalStates == TOTAL_W'(2 * $past(cycleCounts.fetch))) else $error("on-chip rate wrong");
	chk_ext8_word: assert property (instrValid && onlyW && dataAccess.target == TGT_EXTERNAL
		&& !dataAccess.bus16 |=> totalStates == TOTAL_W'($past(cycleCounts.wordData) * ($past(dataAccess.threeState)
		? 6 + 2 * $past(dataAccess.waitCount) : 4))) else $error("external word rate wrong");
	chk_ext16_fetch: assert property (instrValid && onlyF && fetchAccess.target == TGT_EXTERNAL
		&& fetchAccess.bus16 |=> totalStates == TOTAL_W'($past(cycleCounts.fetch) * ($past(fetchAccess.threeState)
		? 3 + $past(fetchAccess.waitCount) : 2))) else $error("external fetch rate wrong");
endmodule

bind eodst_decoder eodst_decoder_asserts #(.TOTAL_W(TOTAL_W)) checker_inst (.ref_clk(ref_clk), .reset(reset),
	.instrValid(instrValid), .instrBytes(instrBytes), .cycleCounts(cycleCounts), .fetchAccess(fetchAccess),
	.dataAccess(dataAccess), .decoded(decoded), .totalStates(totalStates), .resultValid(resultValid));

// ---- test/eodst_bus_model.sv ----
// Far-side model: access conditions of memory, supporting modules and external devices.
// Assumes the bench picks one access map and a wait count per request.
`timescale 1ns/100ps
module eodst_bus_model
	import eodst_pkg::*;
(
	input wire logic [2:0] mode,
	input wire logic [3:0] waitCount,
	output eodst_pkg::eodst_access_t fetchAccess,
	output eodst_pkg::eodst_access_t branchAccess,
	output eodst_pkg::eodst_access_t stackAccess,
	output eodst_pkg::eodst_access_t dataAccess
);
	always_comb begin
		fetchAccess = '{TGT_ONCHIP, 1'b0, 1'b0, 4'h0};
		dataAccess = fetchAccess;
		case (mode)
			3'h1: begin
				fetchAccess = '{TGT_EXTERNAL, 1'b1, 1'b1, waitCount};
				dataAccess = '{TGT_MODULE, 1'b0, 1'b0, 4'h0};
			end
			3'h2: begin
				fetchAccess = '{TGT_EXTERNAL, 1'b0, 1'b1, waitCount};
				dataAccess = fetchAccess;
			end
			3'h3: begin
				fetchAccess = '{TGT_EXTERNAL, 1'b0, 1'b0, 4'h0};
				dataAccess = fetchAccess;
			end
			3'h4: fetchAccess = '{TGT_EXTERNAL, 1'b1, 1'b0, 4'h0};
			3'h5: begin
				fetchAccess = '{TGT_MODULE, 1'b1, 1'b0, 4'h0};
				dataAccess = '{TGT_MODULE, 1'b0, 1'b0, 4'h0};
			end
			default: ;
		endcase
		branchAccess = fetchAccess;
		stackAccess = fetchAccess;
	end
endmodule

// ---- test/eodst_decoder_tb.sv ----
// Testbench for the extended opcode decoder: table of requests issued back to back.
// Assumes the bus model supplies the access conditions of each row.
`timescale 1ns/100ps
module eodst_decoder_tb;
	import eodst_pkg::*;
	localparam int N = 19;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic instrValid = 1'b0;
	logic [31:0] instrBytes = 32'h0000_0000;
	eodst_counts_t cycleCounts = '0;
	logic [2:0] mode = 3'h0;
	logic [3:0] waitCount = 4'h0;
	eodst_access_t fetchAccess, branchAccess, stackAccess, dataAccess;
	eodst_decode_t decoded;
	logic [15:0] totalStates;
	logic resultValid;
	int fails = 0;
	int samples_checked = 0;
	logic [31:0] tBytes [N] = '{32'h7C30_7440, 32'h7C50_74C0, 32'h7D20_7070, 32'h7D20_7120, 32'h7FA5_7200,
		32'h7E3C_7330, 32'h7E3C_77F0, 32'h01C0_5012, 32'h01D0_5334, 32'h01F0_6545, 32'h0140_6910,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000};
	logic [47:0] tCounts [N] = '{48'h0000_0000_0009, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, 48'h0301_0204_0507,
		48'hFF00_0000_0000, 48'h0202_0202_0103, 48'h0100_0001_0100, 48'h0100_0001_0100,
		48'h0000_0000_0300, 48'h0300_0000_0000, 48'h0200_0001_0100};
	logic [6:0] tCond [N] = '{'0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, 7'h11, 7'h22, 7'h2F, 7'h30, 7'h40,
		7'h50};
	eodst_op_t tOp [N] = '{INS_BIT_OR, INS_BIT_IOR, INS_BIT_SET, INS_BIT_INVERT, INS_BIT_CLEAR, INS_BIT_TEST,
		INS_BIT_ILOAD, INS_SIGNED_MULTIPLY, INS_SIGNED_DIVIDE, INS_LOGIC_XOR, INS_CTRL_XFER,
		INS_NONE, INS_NONE, INS_NONE, INS_NONE, INS_NONE, INS_NONE, INS_NONE, INS_NONE};
	logic [15:0] tStates [N] = '{16'h0009, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0, 16'h0025, 16'h01FE, 16'h0027,
		16'h0019, 16'h005A, 16'h000C, 16'h0006, 16'h000F};

	eodst_bus_model partner (.mode(mode), .waitCount(waitCount), .fetchAccess(fetchAccess),
		.branchAccess(branchAccess), .stackAccess(stackAccess), .dataAccess(dataAccess));
	eodst_decoder #(.TOTAL_W(16)) uut (.ref_clk(ref_clk), .reset(reset), .instrValid(instrValid),
		.instrBytes(instrBytes), .cycleCounts(cycleCounts), .fetchAccess(fetchAccess),
		.branchAccess(branchAccess), .stackAccess(stackAccess), .dataAccess(dataAccess),
		.decoded(decoded), .totalStates(totalStates), .resultValid(resultValid));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fails++;
		end
		samples_checked++;
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task t_reset_values;
		check("resultValid", 16'h0000, 16'(resultValid));
		check("totalStates", 16'h0000, totalStates);
	endtask

	// One request per cycle; each answer is judged while the next request is presented
	task t_table;
		for (int i = 0; i <= N; i++) begin
			@(posedge ref_clk);
			#1;
			if (i > 0) begin
				check("resultValid", 16'h0001, 16'(resultValid));
				check("op", 16'(tOp[i-1]), 16'(decoded.op));
				check("valid", 16'(tOp[i-1] != INS_NONE), 16'(decoded.valid));
				check("totalStates", tStates[i-1], totalStates);
				if (tBytes[i-1][31:25] == 7'h3E) begin
					check("regSel", 16'(tBytes[i-1][23:20]), 16'(decoded.regSel));
					check("regDirect", 16'h0001, 16'(decoded.regDirect));
					check("bitNumber", 16'(tBytes[i-1][6:4]), 16'(decoded.bitNumber));
				end
				if (tBytes[i-1][31:25] == 7'h3F) begin
					check("shortAbsoluteField", 16'(tBytes[i-1][23:16]), 16'(decoded.shortAbsoluteField));
					check("absolute", 16'h0001, 16'(decoded.absolute));
				end
			end
			instrValid = i < N;
			if (i < N) begin
				instrBytes = tBytes[i];
				cycleCounts = tCounts[i];
				{mode, waitCount} = tCond[i];
			end
		end
	endtask

	task t_idle_hold;
		repeat (3) @(posedge ref_clk);
		#1;
		check("resultValid", 16'h0000, 16'(resultValid));
		check("totalStates", 16'h000F, totalStates);
	endtask

	task t_mid_reset;
		@(posedge ref_clk);
		#1;
		instrBytes = 32'h7C30_7440;
		cycleCounts = 48'h0000_0000_0009;
		instrValid = 1'b1;
		reset = 1'b1;
		@(posedge ref_clk);
		#1;
		reset = 1'b0;
		instrValid = 1'b0;
		t_reset_values();
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_reset_values();
		t_table();
		t_idle_hold();
		t_mid_reset();
		complete_run();
	end

	// The whole sequence needs about 30 cycles; this bound is far above it
	initial begin
		#5000;
		fails++;
		complete_run();
	end
endmodule
